// file: cmp_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural comparator cores and reference ladder, levels in plain units
module cmp_analog_model (
  input  wire logic [2:0]  channel_on,
  input  wire logic [2:0]  positive_input_select,
  input  wire logic [5:0]  negative_input_select,
  input  wire logic        pos_reference_select,
  input  wire logic [1:0]  neg_reference_select,
  input  wire logic        ladder_power,
  input  wire logic        ladder_range,
  input  wire logic [3:0]  ladder_level,
  input  wire logic [95:0] pin_level,
  output logic      [2:0]  analog_out
);
  localparam int SUPPLY = 240;
  localparam int EXT_REF = 200;
  localparam int BAND_GAP = 120;
  int ladder, pos_ref, neg_ref, vp, vn, sel;
  always_comb begin
    if (!ladder_power) ladder = 0;
    else if (ladder_range) ladder = int'(ladder_level) * SUPPLY / 24;
    else ladder = SUPPLY / 4 + int'(ladder_level) * SUPPLY / 32;
    pos_ref = pos_reference_select ? EXT_REF : ladder;
    case (neg_reference_select)
      2'h0: neg_ref = BAND_GAP / 2;
      2'h1: neg_ref = BAND_GAP;
      2'h2: neg_ref = BAND_GAP / 6;
      default: neg_ref = EXT_REF;
    endcase
    for (int ch = 0; ch < 3; ch++) begin
      sel = int'(negative_input_select[2*ch +: 2]);
      vp = positive_input_select[ch] ? pos_ref : int'(pin_level[32*ch +: 8]);
      vn = (sel == 3) ? neg_ref : int'(pin_level[32*ch + 8*sel + 8 +: 8]);
      // Switched-off core rests low
      analog_out[ch] = channel_on[ch] && (vp > vn);
    end
  end
endmodule
`default_nettype wire

// file: cmp_channel.sv
`timescale 1ns/1ps
`default_nettype none
module cmp_channel (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       raw_out,
  input  wire logic       active,
  input  wire logic       invert,
  input  wire logic [1:0] event_select,
  input  wire logic       flag_clear,
  output logic            result_bit,
  output logic            event_flag,
  output logic            event_pulse
);
  logic sync_a;
  logic sync_b;
  logic prev_val;
  logic polar;
  logic rise;
  logic fall;
  logic hit;

  // ***********************************************************
  // Synchroniser
  // ***********************************************************
  // two-flop chain
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= raw_out;
      sync_b <= sync_a;
    end
  end

  assign polar = sync_b ^ invert;
  assign rise  = polar & ~prev_val;
  assign fall  = ~polar & prev_val;

  // ***********************************************************
  // Event selection
  // ***********************************************************
  always_comb begin
    unique case (event_select)
      cmp_regs_pkg::EVSEL_NONE: hit = 1'b0;
      cmp_regs_pkg::EVSEL_RISE: hit = invert ? fall : rise;
      cmp_regs_pkg::EVSEL_FALL: hit = invert ? rise : fall;
      cmp_regs_pkg::EVSEL_ANY:  hit = rise | fall;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prev_val   <= 1'b0;
      result_bit <= 1'b0;
    end else if (active) begin
      prev_val   <= polar;
      result_bit <= polar;
    end else begin
      prev_val   <= polar;
    end
  end

  // sticky flag gates pulses, set beats clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      event_flag  <= 1'b0;
      event_pulse <= 1'b0;
    end else begin
      event_pulse <= active & hit & ~event_flag;
      if (active & hit)
        event_flag <= 1'b1;
      else if (flag_clear)
        event_flag <= 1'b0;
    end
  end

  // ***********************************************************
  // Checks
  // ***********************************************************
  chk_pulse_needs_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    event_pulse |-> event_flag)
    else $error("event pulse without flag");
  chk_none_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (event_select == cmp_regs_pkg::EVSEL_NONE) |=> !event_pulse)
    else $error("pulse with events off");
  chk_sync_delay: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(raw_out) ##1 $stable(raw_out) |=> sync_b)
    else $error("sync chain not two flops");
  chk_flag_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
    event_flag && !flag_clear |=> event_flag)
    else $error("flag dropped without clear");
  cov_any_event: cover property (@(posedge ref_clk) event_pulse);
endmodule
`default_nettype wire

// file: cmp_regs_pkg.sv
package cmp_regs_pkg;
  // ***********************************************************
  // Register addresses
  // ***********************************************************
  localparam logic [3:0] ADDR_CH1_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CH2_CTRL = 4'h1;
  localparam logic [3:0] ADDR_CH3_CTRL = 4'h2;
  localparam logic [3:0] ADDR_STATUS   = 4'h3;
  localparam logic [3:0] ADDR_LADDER   = 4'h4;
  // ***********************************************************
  // Channel control fields
  // ***********************************************************
  localparam int BIT_CHANNEL_ON     = 15;
  localparam int BIT_PIN_DRIVE      = 14;
  localparam int BIT_RESULT_INVERT  = 13;
  localparam int BIT_EVENT_FLAG     = 9;
  localparam int BIT_RESULT_BIT     = 8;
  localparam int POS_EVENT_SELECT   = 6;
  localparam int BIT_POS_INPUT_SEL  = 4;
  localparam int POS_NEG_INPUT_SEL  = 0;
  localparam logic [15:0] CTRL_WRITE_MASK = 16'he2d3;
  // ***********************************************************
  // Shared status fields
  // ***********************************************************
  localparam int BIT_IDLE_HALT_ALL  = 15;
  localparam int POS_EVENT_COPY     = 8;
  localparam int POS_RESULT_COPY    = 0;
  // ***********************************************************
  // Ladder control fields
  // ***********************************************************
  localparam int BIT_POS_REF_SEL    = 10;
  localparam int POS_NEG_REF_SEL    = 8;
  localparam int BIT_LADDER_POWER   = 7;
  localparam int BIT_LADDER_PIN     = 6;
  localparam int BIT_LADDER_RANGE   = 5;
  localparam int BIT_LADDER_SOURCE  = 4;
  localparam int POS_LADDER_LEVEL   = 0;
  localparam logic [15:0] LADDER_WRITE_MASK = 16'h07ff;
  // ***********************************************************
  // Reset values and encodings
  // ***********************************************************
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] LADDER_RESET = 16'h0000;
  localparam logic [1:0]  EVSEL_NONE   = 2'h0;
  localparam logic [1:0]  EVSEL_RISE   = 2'h1;
  localparam logic [1:0]  EVSEL_FALL   = 2'h2;
  localparam logic [1:0]  EVSEL_ANY    = 2'h3;
endpackage

// file: triple_comparator_control.sv
`timescale 1ns/1ps
`default_nettype none
module triple_comparator_control #(
  parameter int CHANNELS = 3
) (
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  input  wire logic [3:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  output logic      [15:0]         reg_rdata,
  input  wire logic                idle_mode,
  input  wire logic [CHANNELS-1:0] analog_out,
  output logic      [CHANNELS-1:0] channel_on,
  output logic      [CHANNELS-1:0] pin_drive_enable,
  output logic      [CHANNELS-1:0] positive_input_select,
  output logic      [2*CHANNELS-1:0] negative_input_select,
  output logic      [CHANNELS-1:0] event_trigger,
  output logic                     pos_reference_select,
  output logic      [1:0]          neg_reference_select,
  output logic                     ladder_power,
  output logic                     ladder_pin_enable,
  output logic                     ladder_range,
  output logic                     ladder_source,
  output logic      [3:0]          ladder_level
);
  logic [15:0]         ctrl [CHANNELS];
  logic                idle_halt_all;
  logic [15:0]         ladder_ctrl;
  logic [CHANNELS-1:0] result_bit;
  logic [CHANNELS-1:0] event_flag;
  logic [CHANNELS-1:0] event_pulse;
  logic [CHANNELS-1:0] flag_clear;
  logic [CHANNELS-1:0] active;
  logic [15:0]         next_rdata;
  logic                halted;

  assign halted = idle_halt_all & idle_mode;

  // ***********************************************************
  // Channel registers
  // ***********************************************************
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : gen_ch
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          ctrl[g] <= cmp_regs_pkg::CTRL_RESET;
        end else if (reg_write && reg_addr == 4'(g)) begin
          ctrl[g] <= reg_wdata & cmp_regs_pkg::CTRL_WRITE_MASK;
        end
      end
      // Software clears by writing 0 to the flag bit
      assign flag_clear[g] = reg_write && reg_addr == 4'(g)
                             && !reg_wdata[cmp_regs_pkg::BIT_EVENT_FLAG];
      assign active[g] = ctrl[g][cmp_regs_pkg::BIT_CHANNEL_ON] & ~halted;

      cmp_channel u_ch (
        .ref_clk      (ref_clk),
        .sys_rst      (sys_rst),
        .raw_out      (analog_out[g]),
        .active       (active[g]),
        .invert       (ctrl[g][cmp_regs_pkg::BIT_RESULT_INVERT]),
        .event_select (ctrl[g][cmp_regs_pkg::POS_EVENT_SELECT +: 2]),
        .flag_clear   (flag_clear[g]),
        .result_bit   (result_bit[g]),
        .event_flag   (event_flag[g]),
        .event_pulse  (event_pulse[g])
      );

      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          channel_on[g]                    <= 1'b0;
          pin_drive_enable[g]              <= 1'b0;
          positive_input_select[g]         <= 1'b0;
          negative_input_select[2*g +: 2]  <= 2'h0;
          event_trigger[g]                 <= 1'b0;
        end else begin
          channel_on[g]                    <= active[g];
          pin_drive_enable[g]              <= ctrl[g][cmp_regs_pkg::BIT_PIN_DRIVE];
          positive_input_select[g]         <= ctrl[g][cmp_regs_pkg::BIT_POS_INPUT_SEL];
          negative_input_select[2*g +: 2]  <= ctrl[g][cmp_regs_pkg::POS_NEG_INPUT_SEL +: 2];
          // trigger only when flag was clear
          event_trigger[g]                 <= event_pulse[g];
        end
      end

      chk_pin_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_write && reg_addr == 4'(g)
        |-> ##2 pin_drive_enable[g] == $past(reg_wdata[cmp_regs_pkg::BIT_PIN_DRIVE], 2))
        else $error("pin drive enable not applied");
      chk_pos_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_write && reg_addr == 4'(g)
        |-> ##2 positive_input_select[g] == $past(reg_wdata[cmp_regs_pkg::BIT_POS_INPUT_SEL], 2))
        else $error("positive input select not applied");
      chk_neg_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_write && reg_addr == 4'(g)
        |-> ##2 negative_input_select[2*g +: 2] == $past(reg_wdata[cmp_regs_pkg::POS_NEG_INPUT_SEL +: 2], 2))
        else $error("negative input select not applied");
      chk_off_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !ctrl[g][cmp_regs_pkg::BIT_CHANNEL_ON] |=> !channel_on[g])
        else $error("disabled channel still on");
      chk_trigger_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
        event_trigger[g] == $past(event_pulse[g]))
        else $error("trigger does not follow accepted event");
      chk_idle_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        flag_clear[g] && !active[g] |=> !event_flag[g])
        else $error("flag not cleared by write");
      chk_result_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_read && reg_addr == 4'(g)
        |=> reg_rdata[cmp_regs_pkg::BIT_RESULT_BIT] == $past(result_bit[g]))
        else $error("control read result bit wrong");
    end
  endgenerate

  // ***********************************************************
  // Shared status and ladder registers
  // ***********************************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      idle_halt_all <= 1'b0;
    end else if (reg_write && reg_addr == cmp_regs_pkg::ADDR_STATUS) begin
      idle_halt_all <= reg_wdata[cmp_regs_pkg::BIT_IDLE_HALT_ALL];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ladder_ctrl <= cmp_regs_pkg::LADDER_RESET;
    end else if (reg_write && reg_addr == cmp_regs_pkg::ADDR_LADDER) begin
      ladder_ctrl <= reg_wdata & cmp_regs_pkg::LADDER_WRITE_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pos_reference_select <= 1'b0;
      neg_reference_select <= 2'h0;
      ladder_power         <= 1'b0;
      ladder_pin_enable    <= 1'b0;
      ladder_range         <= 1'b0;
      ladder_source        <= 1'b0;
      ladder_level         <= 4'h0;
    end else begin
      pos_reference_select <= ladder_ctrl[cmp_regs_pkg::BIT_POS_REF_SEL];
      neg_reference_select <= ladder_ctrl[cmp_regs_pkg::POS_NEG_REF_SEL +: 2];
      ladder_power         <= ladder_ctrl[cmp_regs_pkg::BIT_LADDER_POWER];
      ladder_pin_enable    <= ladder_ctrl[cmp_regs_pkg::BIT_LADDER_PIN];
      ladder_range         <= ladder_ctrl[cmp_regs_pkg::BIT_LADDER_RANGE];
      ladder_source        <= ladder_ctrl[cmp_regs_pkg::BIT_LADDER_SOURCE];
      ladder_level         <= ladder_ctrl[cmp_regs_pkg::POS_LADDER_LEVEL +: 4];
    end
  end

  // ***********************************************************
  // Read path
  // ***********************************************************
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_addr < 4'(CHANNELS)) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (reg_addr == 4'(i)) begin
          next_rdata = ctrl[i];
          next_rdata[cmp_regs_pkg::BIT_EVENT_FLAG] = event_flag[i];
          next_rdata[cmp_regs_pkg::BIT_RESULT_BIT] = result_bit[i];
        end
      end
    end else if (reg_addr == cmp_regs_pkg::ADDR_STATUS) begin
      next_rdata[cmp_regs_pkg::BIT_IDLE_HALT_ALL] = idle_halt_all;
      next_rdata[cmp_regs_pkg::POS_EVENT_COPY +: CHANNELS] = event_flag;
      next_rdata[cmp_regs_pkg::POS_RESULT_COPY +: CHANNELS] = result_bit;
    end else if (reg_addr == cmp_regs_pkg::ADDR_LADDER) begin
      next_rdata = ladder_ctrl;
    end
  end

  // Data valid only the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ***********************************************************
  // Checks
  // ***********************************************************
  chk_status_events: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_read && reg_addr == cmp_regs_pkg::ADDR_STATUS |=> reg_rdata[10:8] == $past(event_flag))
    else $error("status event copy wrong");
  chk_status_results: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_read && reg_addr == cmp_regs_pkg::ADDR_STATUS |=> reg_rdata[2:0] == $past(result_bit))
    else $error("status result copy wrong");
  chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_read && reg_addr == cmp_regs_pkg::ADDR_LADDER |=> reg_rdata[15:11] == 5'h00)
    else $error("ladder reserved bits not zero");
  chk_ctrl_reserved: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_read && reg_addr == cmp_regs_pkg::ADDR_CH1_CTRL |=> (reg_rdata & 16'h1c2c) == 16'h0000)
    else $error("control reserved bits not zero");
  chk_idle_halts: assert property (@(posedge ref_clk) disable iff (sys_rst)
    idle_halt_all && idle_mode |=> channel_on == '0)
    else $error("comparator runs in idle");
  chk_enable_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !idle_mode && ctrl[0][15] |=> channel_on[0])
    else $error("channel 1 not on");
  chk_level_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_write && reg_addr == cmp_regs_pkg::ADDR_LADDER |-> ##2 ladder_level == $past(reg_wdata[3:0], 2))
    else $error("ladder level not applied");
  chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !reg_read |=> reg_rdata == 16'h0000)
    else $error("read data without read");
  chk_posref_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_write && reg_addr == cmp_regs_pkg::ADDR_LADDER
    |-> ##2 pos_reference_select == $past(reg_wdata[cmp_regs_pkg::BIT_POS_REF_SEL], 2))
    else $error("positive reference select not applied");
  chk_negref_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_write && reg_addr == cmp_regs_pkg::ADDR_LADDER
    |-> ##2 neg_reference_select == $past(reg_wdata[cmp_regs_pkg::POS_NEG_REF_SEL +: 2], 2))
    else $error("negative reference select not applied");
  chk_power_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_write && reg_addr == cmp_regs_pkg::ADDR_LADDER
    |-> ##2 ladder_power == $past(reg_wdata[cmp_regs_pkg::BIT_LADDER_POWER], 2))
    else $error("ladder power not applied");
  chk_ladpin_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_write && reg_addr == cmp_regs_pkg::ADDR_LADDER
    |-> ##2 ladder_pin_enable == $past(reg_wdata[cmp_regs_pkg::BIT_LADDER_PIN], 2))
    else $error("ladder pin enable not applied");
  chk_range_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_write && reg_addr == cmp_regs_pkg::ADDR_LADDER
    |-> ##2 ladder_range == $past(reg_wdata[cmp_regs_pkg::BIT_LADDER_RANGE], 2))
    else $error("ladder range not applied");
  chk_source_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_write && reg_addr == cmp_regs_pkg::ADDR_LADDER
    |-> ##2 ladder_source == $past(reg_wdata[cmp_regs_pkg::BIT_LADDER_SOURCE], 2))
    else $error("ladder source not applied");
  chk_status_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_read && reg_addr == cmp_regs_pkg::ADDR_STATUS
    |=> reg_rdata[cmp_regs_pkg::BIT_IDLE_HALT_ALL] == $past(idle_halt_all))
    else $error("status idle halt bit wrong");
  chk_status_reserved: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_read && reg_addr == cmp_regs_pkg::ADDR_STATUS |=> (reg_rdata & 16'h78f8) == 16'h0000)
    else $error("status reserved bits not zero");
  chk_unmapped_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    reg_read && reg_addr > cmp_regs_pkg::ADDR_LADDER |=> reg_rdata == 16'h0000)
    else $error("unmapped address reads nonzero");
  cov_trigger: cover property (@(posedge ref_clk) |event_trigger);
  cov_clear: cover property (@(posedge ref_clk) event_flag[0] ##1 !event_flag[0]);
  cov_idle: cover property (@(posedge ref_clk) idle_mode && idle_halt_all);
endmodule
`default_nettype wire

// file: triple_comparator_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module triple_comparator_control_tb;
  logic ref_clk, sys_rst, reg_write, reg_read, idle_mode;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [2:0] analog_out, channel_on, pin_drive_enable, positive_input_select, event_trigger;
  logic [5:0] negative_input_select;
  logic pos_reference_select, ladder_power, ladder_pin_enable, ladder_range, ladder_source;
  logic [1:0] neg_reference_select;
  logic [3:0] ladder_level;
  logic [95:0] pin_level;
  int n_errors, checks_done, trig_total;

  triple_comparator_control uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .idle_mode(idle_mode),
    .analog_out(analog_out), .channel_on(channel_on), .pin_drive_enable(pin_drive_enable),
    .positive_input_select(positive_input_select), .negative_input_select(negative_input_select),
    .event_trigger(event_trigger), .pos_reference_select(pos_reference_select),
    .neg_reference_select(neg_reference_select), .ladder_power(ladder_power),
    .ladder_pin_enable(ladder_pin_enable), .ladder_range(ladder_range),
    .ladder_source(ladder_source), .ladder_level(ladder_level));

  cmp_analog_model analog (
    .channel_on(channel_on), .positive_input_select(positive_input_select),
    .negative_input_select(negative_input_select), .pos_reference_select(pos_reference_select),
    .neg_reference_select(neg_reference_select), .ladder_power(ladder_power),
    .ladder_range(ladder_range), .ladder_level(ladder_level), .pin_level(pin_level),
    .analog_out(analog_out));

  // ***********************************************************
  // Clock, trigger tally, helpers
  // ***********************************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) if (!sys_rst) trig_total <= trig_total + int'($countones(event_trigger));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Strobe drops at the taking edge, so the next request starts one edge later
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Event seen on a raw edge; direction is judged on the raw input, before polarity
  function automatic logic hit(input logic [1:0] sel, input logic inv, input logic rising);
    logic up;
    up = rising ^ inv;
    return sel == 2'h3 || (sel == 2'h1 && (inv ? !up : up)) || (sel == 2'h2 && (inv ? up : !up));
  endfunction

  task automatic print_verdict;
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    print_verdict;
  end

  // ***********************************************************
  // Main sequence
  // ***********************************************************
  initial begin
    logic [15:0] rv, d;
    logic [31:0] w;
    logic rh, fh;
    int ch, nsel, base;
    sys_rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    idle_mode = 1'b0;
    pin_level = '0;
    void'($urandom(32'h2a02e522));
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    tick(1);
    check("outputs", 16'({channel_on, pin_drive_enable, event_trigger, ladder_level}), 16'h0);
    for (int a = 0; a < 6; a++) begin
      rd(4'(a), rv);
      check("reset read", rv, 16'h0);
    end
    for (int k = 0; k < 12; k++) begin
      ch = $urandom % 3;
      d = (k == 0) ? 16'hffff : 16'($urandom);
      wr(4'(ch), d);
      tick(1);
      check("enable", 16'(channel_on[ch]), 16'(d[15]));
      check("pin drive", 16'(pin_drive_enable[ch]), 16'(d[14]));
      check("pos input", 16'(positive_input_select[ch]), 16'(d[4]));
      check("neg input", 16'(negative_input_select[2*ch +: 2]), 16'(d[1:0]));
      rd(4'(ch), rv);
      check("ctrl read", rv & 16'hfcff, d & 16'he0d3);
      d = (k == 0) ? 16'hffff : 16'($urandom);
      wr(4'h4, d);
      tick(1);
      check("ladder out", {5'h0, pos_reference_select, neg_reference_select, ladder_power,
            ladder_pin_enable, ladder_range, ladder_source, ladder_level}, d & 16'h07ff);
      rd(4'h4, rv);
      check("ladder read", rv, d & 16'h07ff);
    end
    for (int c = 0; c < 3; c++) wr(4'(c), 16'h8000);
    wr(4'h3, 16'hffff);
    rd(4'h3, rv);
    check("status read", rv & 16'hf8f8, 16'h8000);
    @(posedge ref_clk);
    idle_mode <= 1'b1;
    tick(2);
    check("idle halt", 16'(channel_on), 16'h0);
    wr(4'h3, 16'h0);
    tick(2);
    check("idle run", 16'(channel_on), 16'h7);
    @(posedge ref_clk);
    idle_mode <= 1'b0;
    for (int c = 0; c < 3; c++) wr(4'(c), 16'h0);
    // Every select code with both polarities; other negative pins sit out of reach
    for (int s = 0; s < 8; s++) begin
      ch = $urandom % 3;
      nsel = $urandom % 3;
      w = 32'hfafafa64;
      w[8*(nsel+1) +: 8] = 8'h96;
      @(posedge ref_clk);
      pin_level[32*ch +: 32] <= w;
      d = 16'h8000 | (16'(s[0]) << 13) | (16'(s[2:1]) << 6) | 16'(nsel);
      wr(4'(ch), d);
      tick(8);
      wr(4'(ch), d);
      tick(2);
      base = trig_total;
      @(posedge ref_clk);
      pin_level[32*ch +: 8] <= 8'hc8;
      tick(10);
      rh = hit(s[2:1], s[0], 1'b1);
      check("rise trigger", 16'(trig_total - base), 16'(rh));
      rd(4'(ch), rv);
      check("rise flag", 16'(rv[9]), 16'(rh));
      check("result", 16'(rv[8]), 16'(!s[0]));
      @(posedge ref_clk);
      pin_level[32*ch +: 8] <= 8'h64;
      tick(10);
      fh = !rh && hit(s[2:1], s[0], 1'b0);
      check("fall trigger", 16'(trig_total - base), 16'(rh || fh));
      rd(4'h3, rv);
      check("flag copy", 16'(rv[8+ch]), 16'(rh || fh));
      check("result copy", 16'(rv[ch]), 16'(s[0]));
      wr(4'(ch), 16'h0);
      @(posedge ref_clk);
      pin_level <= '0;
    end
    print_verdict;
  end
endmodule
`default_nettype wire
